// >>> core/gateway_status_word.sv
// status word of the gateway input area
// Function
// - status word occupies input area bytes 0-1
// - bit 15 send, bit 14 confirm
// - bit 13 set after all transactions succeed
// - exchange-complete flag stays set until the offline-online transition or free-format mode
// - free-format mode leaves bit 13 unused
// - bits 12:8 code, low byte qualifier
// - word stored most significant byte first
// - poll code 0x00 retransmission count warning
// - poll codes 0x01/0x02 missing node errors
// - poll codes 0x03 overrun, 0x04 other error
// - error followed by 0x1F once resolved
// - free code 0x00 invalid transaction counter error
// - free code 0x01 frame error warning
// - free code 0x02 offline timeout counter error
// - free codes 0x03 overrun, 0x04 other error
// - free mode uses own table, 0x1F after
// - status word disabled by default
// - flag cleared at offline-online transition and in free-format mode
`timescale 1ns/10ps
`default_nettype none
`include "gsw_regs.svh"
module gateway_status_word
(
  input wire logic clk,
  input wire logic rst,
  input wire gsw_pkg::mode_e mode,
  input wire logic csw_enable,
  input wire logic fieldbus_online,
  input wire logic status_handshake_send,
  input wire logic status_handshake_confirm,
  input wire logic all_done,
  input wire gsw_pkg::event_s ev_retrans,
  input wire gsw_pkg::event_s ev_missing,
  input wire gsw_pkg::event_s ev_overrun,
  input wire gsw_pkg::event_s ev_other,
  input wire gsw_pkg::event_s ev_frame,
  input wire logic cause_cleared,
  input wire logic data_we,
  input wire logic [9:0] data_waddr,
  input wire logic [7:0] data_wdata,
  input wire logic [9:0] fb_raddr,
  output logic [7:0] fb_rdata,
  output logic [15:0] subnet_status_word,
  output logic data_valid_q
);
  // ****************
  // event selection
  // ****************
  // priority: missing/invalid, other, retrans/timeout, overrun, frame
  wire gsw_pkg::event_s ev_sel =
    ev_missing.valid ? ev_missing :
    ev_other.valid ? ev_other :
    ev_retrans.valid ? ev_retrans :
    ev_overrun.valid ? ev_overrun : ev_frame;
  wire free_mode = (mode == gsw_pkg::MODE_FREE);
  // frame error only exists in free format
  wire ev_ok = ev_sel.valid && (free_mode || ev_sel.slot != 3'h1 || ev_missing.valid);
  logic [4:0] map_code; // mapped status code
  logic [7:0] map_qual; // mapped data byte
  logic map_err; // event is of error type
  gsw_code_map u_map
  (
    .mode(mode),
    .slot(ev_ok ? ev_sel.slot : 3'h7),
    .qual_in(ev_sel.qual),
    .code(map_code),
    .qual(map_qual),
    .is_error(map_err)
  );
  // ****************
  // status code register
  // ****************
  gsw_pkg::rpt_e rpt_q; // reporter state
  logic [4:0] code_q; // last code
  logic [7:0] qual_q; // last qualifier
  // an error stays pending under later warnings until its cause clears
  wire err_pending = map_err || (rpt_q == gsw_pkg::RPT_ERR);
  // newest event wins; error resolves to no-error
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rpt_q <= gsw_pkg::RPT_IDLE;
      code_q <= `GSW_CODE_NOERR;
      qual_q <= `GSW_QUAL_NONE;
    end
    else if (ev_ok)
    begin
      code_q <= map_code;
      qual_q <= map_qual;
      rpt_q <= err_pending ? gsw_pkg::RPT_ERR : gsw_pkg::RPT_WARN;
    end
    else if (rpt_q == gsw_pkg::RPT_ERR && cause_cleared)
    begin
      code_q <= `GSW_CODE_NOERR;
      qual_q <= `GSW_QUAL_NONE;
      rpt_q <= gsw_pkg::RPT_IDLE;
    end
  end
  // ****************
  // exchange-complete flag
  // ****************
  logic online_q; // previous online level
  wire go_online = fieldbus_online && !online_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      online_q <= 1'b0;
      data_valid_q <= 1'b0;
    end
    else
    begin
      online_q <= fieldbus_online;
      // free format never uses the flag
      if (free_mode)
      begin
        data_valid_q <= 1'b0;
      end
      // completion in the same cycle as the online edge wins
      else if (all_done)
      begin
        data_valid_q <= 1'b1;
      end
      // otherwise the online transition clears it
      else if (go_online)
      begin
        data_valid_q <= 1'b0;
      end
    end
  end
  // ****************
  // word assembly
  // ****************
  logic [15:0] word_d; // word as assembled
  always_comb
  begin
    word_d = `GSW_WORD_RESET;
    word_d[`GSW_BIT_SEND] = status_handshake_send;
    word_d[`GSW_BIT_CONFIRM] = status_handshake_confirm;
    word_d[`GSW_BIT_VALID] = data_valid_q && !free_mode;
    word_d[`GSW_CODE_HI:`GSW_CODE_LO] = code_q;
    word_d[7:0] = qual_q;
  end
  // disabled word reads zero and is not written
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      subnet_status_word <= `GSW_WORD_RESET;
    end
    else
    begin
      subnet_status_word <= csw_enable ? word_d : `GSW_WORD_RESET;
    end
  end
  // ****************
  // input area
  // ****************
  // status word overrides area bytes 0 and 1 when enabled
  wire hit_hi = csw_enable && (fb_raddr == `GSW_OFF_HI);
  wire hit_lo = csw_enable && (fb_raddr == `GSW_OFF_LO);
  logic hit_hi_q; // aligned with memory latency
  logic hit_lo_q; // aligned with memory latency
  logic [7:0] mem_rdata; // memory read data
  gsw_area_mem u_mem
  (
    .clk(clk),
    .we(data_we),
    .waddr(data_waddr),
    .wdata(data_wdata),
    .raddr(fb_raddr),
    .rdata(mem_rdata)
  );
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hit_hi_q <= 1'b0;
      hit_lo_q <= 1'b0;
    end
    else
    begin
      hit_hi_q <= hit_hi;
      hit_lo_q <= hit_lo;
    end
  end
  // byte 0 is high byte (MSB first)
  wire [7:0] rd_mux = hit_hi_q ? subnet_status_word[15:8] :
    hit_lo_q ? subnet_status_word[7:0] : mem_rdata;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fb_rdata <= 8'h00;
    end
    else
    begin
      fb_rdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// >>> core/gsw_regs.svh
// constants of the gateway status word
`ifndef GSW_REGS_SVH
`define GSW_REGS_SVH
`define GSW_OFF_HI 10'h000
`define GSW_OFF_LO 10'h001
`define GSW_AREA_SIZE 10'h200
`define GSW_BIT_SEND 4'hF
`define GSW_BIT_CONFIRM 4'hE
`define GSW_BIT_VALID 4'hD
`define GSW_CODE_HI 4'hC
`define GSW_CODE_LO 4'h8
`define GSW_WORD_RESET 16'h0000
`define GSW_CODE_NOERR 5'h1F
`define GSW_CODE_0 5'h00
`define GSW_CODE_1 5'h01
`define GSW_CODE_2 5'h02
`define GSW_CODE_3 5'h03
`define GSW_CODE_4 5'h04
`define GSW_NUM_EVENTS 3'h5
`define GSW_QUAL_NONE 8'h00
`endif

// >>> core/gsw_pkg.sv
// types of the gateway status word
package gsw_pkg;
  // operating mode of the sub-network side
  typedef enum logic [1:0] {
    MODE_POLL = 2'b00,
    MODE_SERIAL = 2'b01,
    MODE_FREE = 2'b10
  } mode_e;
  // one status event: which code slot and its data byte
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [7:0] qual;
  } event_s;
  // reporter state
  typedef enum logic [1:0] {
    RPT_IDLE = 2'b00,
    RPT_WARN = 2'b01,
    RPT_ERR = 2'b10
  } rpt_e;
endpackage

// >>> core/gsw_area_mem.sv
// small input area memory, registered read
`timescale 1ns/10ps
`default_nettype none
module gsw_area_mem
(
  input wire logic clk,
  input wire logic we,
  input wire logic [9:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [9:0] raddr,
  output logic [7:0] rdata
);
  // ****************
  // storage
  // ****************
  logic [7:0] mem [0:511]; // byte array of the input area
  // write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr[8:0]] <= wdata;
    end
  end
  // registered read port
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr[8:0]];
  end
endmodule
`default_nettype wire

// >>> core/gsw_code_map.sv
// maps an event slot to the code table of the current mode
`timescale 1ns/10ps
`default_nettype none
`include "gsw_regs.svh"
module gsw_code_map
(
  input wire gsw_pkg::mode_e mode,
  input wire logic [2:0] slot,
  input wire logic [7:0] qual_in,
  output logic [4:0] code,
  output logic [7:0] qual,
  output logic is_error
);
  // free-format mode uses its own table
  wire free_mode = (mode == gsw_pkg::MODE_FREE);
  // slot 5 and above means no error
  wire no_err = (slot >= `GSW_NUM_EVENTS);
  // data-less codes in free format: 1, 3, 4
  wire free_blank = free_mode && (slot == 3'h1 || slot == 3'h3 || slot == 3'h4);
  // error types: poll 1,2,4 ; free 0,2,4
  wire err_poll = (slot == 3'h1) || (slot == 3'h2) || (slot == 3'h4);
  wire err_free = (slot == 3'h0) || (slot == 3'h2) || (slot == 3'h4);
  assign code = no_err ? `GSW_CODE_NOERR : {2'b00, slot};
  assign qual = (no_err || free_blank) ? `GSW_QUAL_NONE : qual_in;
  assign is_error = !no_err && (free_mode ? err_free : err_poll);
endmodule
`default_nettype wire

// >>> tb/gsw_props.sv
// port assertions for the gateway status word
`timescale 1ns/10ps
`default_nettype none
module gsw_props
(
  input wire logic clk,
  input wire logic rst,
  input wire gsw_pkg::mode_e mode,
  input wire logic csw_enable,
  input wire logic fieldbus_online,
  input wire logic status_handshake_send,
  input wire logic status_handshake_confirm,
  input wire logic all_done,
  input wire gsw_pkg::event_s ev_retrans,
  input wire gsw_pkg::event_s ev_missing,
  input wire gsw_pkg::event_s ev_overrun,
  input wire gsw_pkg::event_s ev_other,
  input wire gsw_pkg::event_s ev_frame,
  input wire logic cause_cleared,
  input wire logic [9:0] fb_raddr,
  input wire logic [7:0] fb_rdata,
  input wire logic [15:0] subnet_status_word,
  input wire logic data_valid_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // enabled and in a polling-master mode
  wire run = csw_enable && mode != gsw_pkg::MODE_FREE;
  wire no_ev = run && !(ev_retrans.valid || ev_missing.valid || ev_overrun.valid
    || ev_other.valid || ev_frame.valid);
  wire quiet = no_ev && !cause_cleared;
  wire [4:0] code = subnet_status_word[12:8];
  // data-bearing missing-node event
  sequence miss_ev;
    run && ev_missing.valid && !cause_cleared && ev_missing.slot inside {3'h1, 3'h2};
  endsequence
  // resolve request while an error code shows
  sequence err_clear;
    no_ev && cause_cleared && code inside {5'h01, 5'h02, 5'h04};
  endsequence
  flags_copy_a: assert property ((csw_enable && $stable({status_handshake_send,
    status_handshake_confirm}))[*3] |-> subnet_status_word[15:14] ==
    {status_handshake_send, status_handshake_confirm}) else $error("flag copy wrong");
  word_off_a: assert property (!csw_enable[*3] |-> subnet_status_word == 16'h0000)
    else $error("word not zero while disabled");
  valid_set_a: assert property ((all_done && run && fieldbus_online)[*3]
    |-> ##[0:8] data_valid_q) else $error("exchange flag not set");
  valid_keep_a: assert property (data_valid_q && run && $stable(fieldbus_online)
    ##1 run && $stable(fieldbus_online) |-> data_valid_q) else $error("flag dropped");
  free_flag_a: assert property ((csw_enable && mode == gsw_pkg::MODE_FREE)[*3]
    |-> !subnet_status_word[13]) else $error("flag used in free mode");
  code_map_a: assert property (miss_ev ##1 quiet |-> ##1 code ==
    {2'b00, $past(ev_missing.slot, 2)} && subnet_status_word[7:0] ==
    $past(ev_missing.qual, 2)) else $error("code or qualifier wrong");
  err_clear_a: assert property (quiet[*2] ##1 err_clear ##1 quiet
    |-> ##1 code == 5'h1F) else $error("no error code missing");
  byte_order_a: assert property (csw_enable && fb_raddr < 10'h002 ##1 csw_enable[*2]
    |-> fb_rdata == ($past(fb_raddr, 2) == 10'h000 ? $past(subnet_status_word[15:8])
    : $past(subnet_status_word[7:0]))) else $error("area byte wrong");
endmodule
bind gateway_status_word gsw_props gsw_props_i (.clk, .rst, .mode, .csw_enable,
  .fieldbus_online, .status_handshake_send, .status_handshake_confirm, .all_done,
  .ev_retrans, .ev_missing, .ev_overrun, .ev_other, .ev_frame, .cause_cleared,
  .fb_raddr, .fb_rdata, .subnet_status_word, .data_valid_q);
`default_nettype wire

// >>> tb/fb_host.sv
// fieldbus control system model reading the input area
`timescale 1ns/10ps
`default_nettype none
module fb_host
(
  input wire logic clk,
  input wire logic [7:0] fb_rdata,
  output logic [9:0] fb_raddr,
  output logic fieldbus_online
);
  initial fb_raddr = 10'h3FF;
  initial fieldbus_online = 1'b1;
  // fetch the status word, high byte first
  task automatic read_word(output logic [15:0] w);
    @(posedge clk) fb_raddr <= 10'h000;
    @(posedge clk) fb_raddr <= 10'h001;
    @(posedge clk) #1 w[15:8] = fb_rdata;
    @(posedge clk) #1 w[7:0] = fb_rdata;
  endtask
  // link drops and returns
  task automatic bounce;
    @(posedge clk) fieldbus_online <= 1'b0;
    @(posedge clk) fieldbus_online <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_gateway_status_word.sv
// self-checking bench for the gateway status word
`timescale 1ns/10ps
`default_nettype none
module tb_gateway_status_word;
  logic clk = 1'b0, rst = 1'b1, csw = 1'b1, send = 1'b0, conf = 1'b0, done = 1'b0;
  logic clr = 1'b0, we = 1'b0, online;
  gsw_pkg::mode_e mode = gsw_pkg::MODE_POLL;
  gsw_pkg::event_s ev [5] = '{default: '0};
  logic [9:0] raddr;
  logic [7:0] rdata;
  logic [7:0] wdata = 8'hA5;
  logic [15:0] word, w;
  int err_count = 0, n_tests = 0;
  typedef struct {gsw_pkg::mode_e m; int e; logic [2:0] s; logic [7:0] q; logic [15:0] x;} row_s;
  // mode, event port index, slot, qualifier, expected word
  row_s rows [11] = '{
    '{gsw_pkg::MODE_POLL, 1, 3'h1, 8'h05, 16'h0105},
    '{gsw_pkg::MODE_SERIAL, 1, 3'h2, 8'h03, 16'h0203},
    '{gsw_pkg::MODE_POLL, 0, 3'h0, 8'h07, 16'h0007},
    '{gsw_pkg::MODE_POLL, 2, 3'h3, 8'h09, 16'h0309},
    '{gsw_pkg::MODE_POLL, 3, 3'h4, 8'h0B, 16'h040B},
    '{gsw_pkg::MODE_POLL, 4, 3'h1, 8'h66, 16'h040B},
    '{gsw_pkg::MODE_FREE, 0, 3'h0, 8'h21, 16'h0021},
    '{gsw_pkg::MODE_FREE, 4, 3'h1, 8'h33, 16'h0100},
    '{gsw_pkg::MODE_FREE, 3, 3'h2, 8'h12, 16'h0212},
    '{gsw_pkg::MODE_FREE, 2, 3'h3, 8'h44, 16'h0300},
    '{gsw_pkg::MODE_FREE, 3, 3'h4, 8'h55, 16'h0400}};
  gateway_status_word gateway_status_word_i (.clk(clk), .rst(rst), .mode(mode),
    .csw_enable(csw), .fieldbus_online(online), .status_handshake_send(send),
    .status_handshake_confirm(conf), .all_done(done), .ev_retrans(ev[0]),
    .ev_missing(ev[1]), .ev_overrun(ev[2]), .ev_other(ev[3]), .ev_frame(ev[4]),
    .cause_cleared(clr), .data_we(we), .data_waddr(10'h000), .data_wdata(wdata),
    .fb_raddr(raddr), .fb_rdata(rdata), .subnet_status_word(word), .data_valid_q());
  fb_host fb_host_i (.clk(clk), .fb_rdata(rdata), .fb_raddr(raddr), .fieldbus_online(online));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle event, then let the word settle
  task automatic fire(input int e, input logic [2:0] s, input logic [7:0] q);
    @(posedge clk) ev[e] <= {1'b1, s, q};
    @(posedge clk) ev[e] <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic clear;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // bounded wait on the exchange flag
  task automatic wait_bit(input logic v);
    for (int k = 0; k < 50 && word[13] !== v; k++)
      @(posedge clk);
    #1 chk({15'h0000, word[13]}, {15'h0000, v});
    if (word[13] !== v)
      close_out;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk(word, 16'h0000);
    @(posedge clk) #1 chk(word, 16'h1F00);
    foreach (rows[i])
    begin
      @(posedge clk) mode <= rows[i].m;
      fire(rows[i].e, rows[i].s, rows[i].q);
      chk(word, rows[i].x);
      fb_host_i.read_word(w);
      chk(w, rows[i].x);
    end
    clear;
    chk(word, 16'h1F00);
    @(posedge clk) mode <= gsw_pkg::MODE_POLL;
    fire(2, 3'h3, 8'h09);
    clear;
    chk(word, 16'h0309);
    fire(1, 3'h1, 8'h05);
    clear;
    chk(word, 16'h1F00);
    fire(1, 3'h2, 8'h02);
    fire(0, 3'h0, 8'h08);
    clear;
    chk(word, 16'h1F00);
    @(posedge clk) {send, conf} <= 2'b10;
    repeat (3) @(posedge clk);
    #1 chk(word, 16'h9F00);
    @(posedge clk) {send, conf} <= 2'b01;
    @(posedge clk) done <= 1'b1;
    wait_bit(1'b1);
    @(posedge clk) done <= 1'b0;
    fire(3, 3'h4, 8'h01);
    chk(word, 16'h6401);
    fb_host_i.bounce;
    wait_bit(1'b0);
    @(posedge clk) done <= 1'b1;
    wait_bit(1'b1);
    @(posedge clk) mode <= gsw_pkg::MODE_FREE;
    wait_bit(1'b0);
    // reset in mid-run: word clears, then shows no-error with live flags
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1 chk(word, 16'h0000);
    @(posedge clk) #1 chk(word, 16'h5F00);
    @(posedge clk) csw <= 1'b0;
    we <= 1'b1;
    @(posedge clk) we <= 1'b0;
    repeat (3) @(posedge clk);
    fb_host_i.read_word(w);
    chk({w[15:8], word[15:8]}, 16'hA500);
    close_out;
  end
endmodule
`default_nettype wire
